// >>> src/rfir_top.sv
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module rfir_top
	import rfir_pkg::*;
(
	input  wire logic              clk_sys_i,
	input  wire logic              reset_n_i,
	input  wire rfir_bus_req_type  bus_req_i,
	input  wire rfir_sources_type  sources_i,
	output var  logic [DATA_W-1:0] rdata_o,
	output var  logic              irq_request_n_o
);

	rfir_sources_type  src_meta;
	rfir_sources_type  src_sync;
	logic              burn_running_d;
	logic [DATA_W-1:0] buck_fault_flags;
	logic [DATA_W-1:0] buck_fault_masks;
	logic [DATA_W-1:0] misc_event_flags;
	logic [DATA_W-1:0] misc_event_masks;
	logic [DATA_W-1:0] buck_fault_live;
	logic [DATA_W-1:0] misc_event_live;
	logic [DATA_W-1:0] buck_events;
	logic [DATA_W-1:0] misc_events;
	logic [DATA_W-1:0] next_buck_fault_flags;
	logic [DATA_W-1:0] next_misc_event_flags;
	logic [DATA_W-1:0] next_rdata;
	logic              fuse_burn_done_pulse;

	// sticky update: hold, clear by ones written, event set wins
	function automatic logic [DATA_W-1:0] w1c_update(
		input logic [DATA_W-1:0] flags,
		input logic [DATA_W-1:0] events,
		input logic              hit,
		input logic [DATA_W-1:0] wdata,
		input logic [DATA_W-1:0] impl
	);
		logic [DATA_W-1:0] clr;
		clr = hit ? wdata : '0;
		return ((flags & ~clr) | events) & impl;
	endfunction

	function automatic logic wr_hit(input rfir_bus_req_type req, input logic [ADDR_W-1:0] ofs);
		return req.wr && (req.addr == ofs);
	endfunction

	// two-stage synchroniser for all the fault and event sources
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			src_meta <= '0;
			src_sync <= '0;
		end else begin
			src_meta <= sources_i;
			src_sync <= src_meta;
		end
	end

	// burn running delayed for end-of-sequence detection
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			burn_running_d <= 1'b0;
		end else begin
			burn_running_d <= src_sync.fuse_burn_running;
		end
	end

	assign fuse_burn_done_pulse = burn_running_d & ~src_sync.fuse_burn_running;

	always_comb begin
		buck_fault_live            = '0;
		buck_fault_live[BUCK3_BIT]  = src_sync.buck_three_overcurrent;
		buck_fault_live[BUCK2_BIT]  = src_sync.buck_two_overcurrent;
		buck_fault_live[BUCK1B_BIT] = src_sync.buck_one_b_overcurrent;
		buck_fault_live[BUCK1A_BIT] = src_sync.buck_one_a_overcurrent;
	end

	always_comb begin
		misc_event_live              = '0;
		misc_event_live[FUSE_ER_BIT] = src_sync.fuse_mem_error;
		misc_event_live[FUSE_DN_BIT] = src_sync.fuse_burn_running;
		misc_event_live[OVP_BIT]     = src_sync.supply_input_overvoltage;
		misc_event_live[BOOST_BIT]   = src_sync.boost_regulator_overcurrent;
	end

	// flags are set for as long as the condition persists; the fuse done flag is set once, by the pulse when the burn ends
	always_comb begin
		buck_events             = '0;
		buck_events[BUCK3_BIT]  = src_sync.buck_three_overcurrent;
		buck_events[BUCK2_BIT]  = src_sync.buck_two_overcurrent;
		buck_events[BUCK1B_BIT] = src_sync.buck_one_b_overcurrent;
		buck_events[BUCK1A_BIT] = src_sync.buck_one_a_overcurrent;
	end

	always_comb begin
		misc_events              = '0;
		misc_events[FUSE_ER_BIT] = src_sync.fuse_mem_error;
		misc_events[FUSE_DN_BIT] = fuse_burn_done_pulse;
		misc_events[OVP_BIT]     = src_sync.supply_input_overvoltage;
		misc_events[BOOST_BIT]   = src_sync.boost_regulator_overcurrent;
	end

	assign next_buck_fault_flags = w1c_update(buck_fault_flags, buck_events,
		wr_hit(bus_req_i, BUCK_FAULT_FLAGS_OFS), bus_req_i.wdata, BUCK_IMPL_MASK);
	assign next_misc_event_flags = w1c_update(misc_event_flags, misc_events,
		wr_hit(bus_req_i, MISC_EVENT_FLAGS_OFS), bus_req_i.wdata, MISC_IMPL_MASK);

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			buck_fault_flags <= FLAGS_RESET;
			misc_event_flags <= FLAGS_RESET;
		end else begin
			buck_fault_flags <= next_buck_fault_flags;
			misc_event_flags <= next_misc_event_flags;
		end
	end

	// mask registers, only implemented positions stored
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			buck_fault_masks <= BUCK_MASKS_RESET;
			misc_event_masks <= MISC_MASKS_RESET;
		end else begin
			if (wr_hit(bus_req_i, BUCK_FAULT_MASKS_OFS)) begin
				buck_fault_masks <= bus_req_i.wdata & BUCK_IMPL_MASK;
			end
			if (wr_hit(bus_req_i, MISC_EVENT_MASKS_OFS)) begin
				misc_event_masks <= bus_req_i.wdata & MISC_IMPL_MASK;
			end
		end
	end

	// read mux; live registers ignore writes
	always_comb begin
		next_rdata = RDATA_RESET;
		if (bus_req_i.rd) begin
			case (bus_req_i.addr)
				BUCK_FAULT_FLAGS_OFS: next_rdata = buck_fault_flags;
				BUCK_FAULT_MASKS_OFS: next_rdata = buck_fault_masks;
				BUCK_FAULT_LIVE_OFS:  next_rdata = buck_fault_live;
				MISC_EVENT_FLAGS_OFS: next_rdata = misc_event_flags;
				MISC_EVENT_MASKS_OFS: next_rdata = misc_event_masks;
				MISC_EVENT_LIVE_OFS:  next_rdata = misc_event_live;
				default:              next_rdata = RDATA_RESET;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= RDATA_RESET;
		end else begin
			rdata_o <= next_rdata;
		end
	end

	// interrupt request from the flag registers as they now stand
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_request_n_o <= 1'b1;
		end else begin
			irq_request_n_o <= ~(|(buck_fault_flags & ~buck_fault_masks) |
				|(misc_event_flags & ~misc_event_masks));
		end
	end

endmodule

`default_nettype wire

// >>> src/rfir_pkg.sv
package rfir_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// register offsets
	localparam logic [ADDR_W-1:0] BUCK_FAULT_FLAGS_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] BUCK_FAULT_MASKS_OFS = 8'h01;
	localparam logic [ADDR_W-1:0] BUCK_FAULT_LIVE_OFS  = 8'h02;
	localparam logic [ADDR_W-1:0] MISC_EVENT_FLAGS_OFS = 8'h03;
	localparam logic [ADDR_W-1:0] MISC_EVENT_MASKS_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] MISC_EVENT_LIVE_OFS  = 8'h05;

	// buck group field positions
	localparam int unsigned BUCK1A_BIT = 0;
	localparam int unsigned BUCK1B_BIT = 1;
	localparam int unsigned BUCK2_BIT  = 3;
	localparam int unsigned BUCK3_BIT  = 4;

	// misc group field positions
	localparam int unsigned BOOST_BIT   = 0;
	localparam int unsigned OVP_BIT     = 2;
	localparam int unsigned FUSE_DN_BIT = 6;
	localparam int unsigned FUSE_ER_BIT = 7;

	localparam logic [DATA_W-1:0] BUCK_IMPL_MASK = 8'h1B;
	localparam logic [DATA_W-1:0] MISC_IMPL_MASK = 8'hC5;

	// values after reset
	localparam logic [DATA_W-1:0] FLAGS_RESET      = 8'h00;
	localparam logic [DATA_W-1:0] BUCK_MASKS_RESET = 8'h1B;
	localparam logic [DATA_W-1:0] MISC_MASKS_RESET = 8'hC5;
	localparam logic [DATA_W-1:0] RDATA_RESET      = 8'h00;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} rfir_bus_req_type;

	// raw fault and event sources, asynchronous to clk_sys_i
	typedef struct packed {
		logic buck_three_overcurrent;
		logic buck_two_overcurrent;
		logic buck_one_b_overcurrent;
		logic buck_one_a_overcurrent;
		logic boost_regulator_overcurrent;
		logic supply_input_overvoltage;
		logic fuse_mem_error;
		logic fuse_burn_running;
	} rfir_sources_type;

endpackage

// >>> src/rfir_dummy_unused.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> tb/rfir_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module rfir_monitor
	import rfir_pkg::*;
(
	input wire logic              clk_sys_i,
	input wire logic              reset_n_i,
	input wire rfir_bus_req_type  bus_req_i,
	input wire rfir_sources_type  sources_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic              irq_request_n_o
);
	logic       rd;
	logic [7:0] a;
	assign rd = bus_req_i.rd;
	assign a = bus_req_i.addr;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	rdata_idle_a: assert property (!rd |=> rdata_o == 8'h00) else $error("rdata not idle");
	unmapped_rd_a: assert property (rd && a > 8'h05 |=> rdata_o == 8'h00) else $error("unmapped read");
	buck_unimpl_a: assert property (rd && a <= 8'h02 |=> (rdata_o & ~BUCK_IMPL_MASK) == 8'h00)
		else $error("buck reserved bits");
	misc_unimpl_a: assert property (rd && a inside {[8'h03:8'h05]} |=> (rdata_o & ~MISC_IMPL_MASK) == 8'h00)
		else $error("misc reserved bits");
	mask_readback_a: assert property (bus_req_i.wr && a == 8'h01 ##2 rd && a == 8'h01
		|=> rdata_o == ($past(bus_req_i.wdata, 3) & BUCK_IMPL_MASK)) else $error("mask readback");
	buck_live_a: assert property (rd && a == 8'h02 && $past(sources_i.buck_one_a_overcurrent, 2)
		&& $past(sources_i.buck_one_a_overcurrent, 3) |=> rdata_o[0]) else $error("live bit lost");
	boost_live_a: assert property (rd && a == 8'h05 && !$past(sources_i.boost_regulator_overcurrent, 2)
		&& !$past(sources_i.boost_regulator_overcurrent, 3) |=> !rdata_o[0]) else $error("live bit stuck");
	flag_hold_a: assert property (rd && a == 8'h00 && $past(sources_i.buck_three_overcurrent, 4)
		|=> rdata_o[4]) else $error("flag lost");
	irq_rise_a: assert property ($rose(irq_request_n_o) |-> $past(bus_req_i.wr) || $past(bus_req_i.wr, 2))
		else $error("irq rose without write");
endmodule
bind rfir_top rfir_monitor rfir_monitor_i(.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .bus_req_i(bus_req_i),
	.sources_i(sources_i), .rdata_o(rdata_o), .irq_request_n_o(irq_request_n_o));
`default_nettype wire

// >>> tb/rfir_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rfir_host_model
	import rfir_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic [DATA_W-1:0] rdata_i,
	output var  rfir_bus_req_type  req_o
);
	initial req_o = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_i);
		req_o.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_i);
		req_o.rd <= 1'b0;
		@(negedge clk_i);
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import rfir_pkg::*;
	logic             clk_sys_i;
	logic             reset_n_i;
	logic             irq_n;
	logic [7:0]       rdata;
	logic [7:0]       d;
	rfir_bus_req_type req;
	rfir_sources_type src;
	int               bad_count;
	int               n_compared;
	rfir_top rfir_top_i(.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .bus_req_i(req), .sources_i(src),
		.rdata_o(rdata), .irq_request_n_o(irq_n));
	rfir_host_model rfir_host_model_i(.clk_i(clk_sys_i), .rdata_i(rdata), .req_o(req));
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic rdc(input string w, input logic [7:0] a, input logic [7:0] e);
		rfir_host_model_i.rd(a, d);
		chk(w, e, d);
	endtask
	task automatic t_src(input int s, input logic [7:0] fo, input logic [7:0] b);
		@(posedge clk_sys_i) src[s] <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		rdc("live on", fo + 8'h02, b);
		rfir_host_model_i.wr(fo, b);
		rdc("flag vs clear", fo, (s == 0) ? 8'h00 : b);
		@(posedge clk_sys_i) src[s] <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		rdc("live off", fo + 8'h02, 8'h00);
		rdc("flag", fo, b);
		chk("irq masked", 8'h01, {7'h00, irq_n});
		rfir_host_model_i.wr(fo + 8'h01, ~b);
		repeat (3) @(posedge clk_sys_i);
		chk("irq", 8'h00, {7'h00, irq_n});
		rfir_host_model_i.wr(fo, ~b);
		rdc("flag w0", fo, b);
		rfir_host_model_i.wr(fo, b);
		repeat (3) @(posedge clk_sys_i);
		chk("irq off", 8'h01, {7'h00, irq_n});
		rdc("flag w1", fo, 8'h00);
		rfir_host_model_i.wr(fo + 8'h01, 8'hFF);
	endtask
	task automatic t_regs();
		logic [7:0] e [7] = '{8'h00, 8'h1B, 8'h00, 8'h00, 8'hC5, 8'h00, 8'h00};
		for (int i = 0; i < 7; i++) rdc("reset value", i[7:0], e[i]);
		rfir_host_model_i.wr(8'h01, 8'hE4);
		rdc("buck mask", 8'h01, 8'h00);
		rfir_host_model_i.wr(8'h04, 8'h3A);
		rdc("misc mask", 8'h04, 8'h00);
		rfir_host_model_i.wr(8'h01, 8'hFF);
		rfir_host_model_i.wr(8'h04, 8'hFF);
		rfir_host_model_i.wr(8'h05, 8'hFF);
		rfir_host_model_i.wr(8'h06, 8'hFF);
		rdc("live ro", 8'h05, 8'h00);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		reset_n_i = 1'b0;
		src = '0;
		repeat (3) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		t_regs();
		t_src(7, 8'h00, 8'h10);
		t_src(6, 8'h00, 8'h08);
		t_src(5, 8'h00, 8'h02);
		t_src(4, 8'h00, 8'h01);
		t_src(3, 8'h03, 8'h01);
		t_src(2, 8'h03, 8'h04);
		t_src(1, 8'h03, 8'h80);
		t_src(0, 8'h03, 8'h40);
		tally_and_finish();
	end
	initial begin
		#1000000;
		bad_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
